//--- hdl/rbc_reset_brownout.sv
// top of the reset source and brown-out control block with Avalon-MM registers
// Operation
// - five reset sources: power-on, pin, software, watchdog, brown-out.
// - any reset restores registers; cause flags depend on the source. Source resets here keep the event flag and the interrupt status and mask.
// - cpu held in reset while supply is below the power-on threshold.
// - after power-on, wait for oscillator, then release cpu at address zero.
// - cold-start flag set to one when power-on reset completes.
// - cold-start flag keeps its value through all other resets.
// - four port-1 pins forced quasi-bidirectional while in reset.
// - internal ram is not initialised; software loads it.
// - with brown-out reset enabled, any level crossing resets the cpu.
// - each reset loads detect enable with inverted config word two bit 7.
// - writing one enables brown-out detection, zero disables it.
// - config level one selects 2.7 V (select 0); zero selects 3.8 V.
// - a drop, or with reset enable set any crossing, sets the event flag; interrupt when both enables set.
// - reset enable zero: no reset, flag still set on supply drop.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module rbc_reset_brownout #(
	parameter int HOLD_CYCLES = rbc_pkg::SRC_HOLD_CYCLES
) (
	input  wire logic                        CLK,
	input  wire logic                        RESET_N,
	input  wire logic                        OSC_READY,
	input  wire logic                        RST_PIN_N,
	input  wire logic                        WATCHDOG_EXPIRE,
	input  wire logic                        SUPPLY_ABOVE_LEVEL,
	input  wire logic                        CFG_BROWNOUT_DISABLE,
	input  wire logic                        CFG_BROWNOUT_LEVEL,
	input  wire logic                        BROWNOUT_IRQ_ENABLE,
	input  wire logic                        GLOBAL_IRQ_ENABLE,
	input  wire logic [rbc_pkg::ADDR_W-1:0]  ADDRESS,
	input  wire logic                        READ,
	input  wire logic                        WRITE,
	input  wire logic [rbc_pkg::DATA_W-1:0]  WRITEDATA,
	input  wire logic [3:0]                  BYTEENABLE,
	output logic      [rbc_pkg::DATA_W-1:0]  READDATA,
	output logic                             WAITREQUEST,
	output logic                             CPU_RESET,
	output logic      [15:0]                 CPU_START_ADDRESS,
	output logic      [3:0]                  P1_QUASI_FORCE,
	output logic                             BROWNOUT_DETECT_ENABLE,
	output logic                             BROWNOUT_LEVEL_SELECT,
	output logic                             BROWNOUT_IRQ,
	output logic                             IRQ
);
	logic                       wait_reg;
	logic [rbc_pkg::DATA_W-1:0] rdata_reg;
	logic [rbc_pkg::REG_W-1:0]  power_control_reg;
	logic                       detect_en_reg;
	logic                       level_sel_reg;
	logic                       reset_en_reg;
	logic                       event_flag_reg;
	logic [rbc_pkg::IRQ_W-1:0]  irq_status_reg;
	logic [rbc_pkg::IRQ_W-1:0]  irq_mask_reg;
	logic [rbc_pkg::CAUSE_W-1:0] cause_reg;
	logic                       sw_req_reg;
	logic                       cpu_reset_out_reg;
	logic [3:0]                 p1_force_reg;
	logic                       bod_irq_reg;
	logic                       irq_reg;
	logic                       det_en_out_reg;
	logic                       level_out_reg;

	logic                       supply_rise;
	logic                       supply_fall;
	logic                       seq_reset;
	logic                       por_done;
	logic                       cpu_reset_prev_reg;

	logic                       access;
	logic                       wr_lo;
	logic                       hit_pc;
	logic                       hit_sm;
	logic                       hit_ist;
	logic                       hit_imk;
	logic                       hit_cause;
	logic                       hit_cmd;
	logic                       crossing;
	logic                       flag_set;
	logic                       bod_reset_req;
	logic                       src_req;
	logic [rbc_pkg::REG_W-1:0]  sm_view;

	// comparator crossing detection
	rbc_sync_edge #(
		.RESET_LEVEL(1'b1)
	) u_supply_sync (
		.clk      (CLK),
		.rst_n    (RESET_N),
		.async_in (SUPPLY_ABOVE_LEVEL),
		.level    (),
		.rise     (supply_rise),
		.fall     (supply_fall)
	);

	// detection only acts while enabled and the cpu runs
	assign crossing      = detect_en_reg & ~seq_reset & (supply_rise | supply_fall);
	// without reset enable only a drop raises the flag
	assign flag_set      = detect_en_reg & ~seq_reset &
	                       (reset_en_reg ? (supply_rise | supply_fall) : supply_fall);
	assign bod_reset_req = crossing & reset_en_reg;

	// software, watchdog and brown-out requests; pin is a held level
	assign src_req = sw_req_reg | WATCHDOG_EXPIRE | bod_reset_req;

	// reset sequencer; RESET_N is the asynchronous power-on reset
	rbc_reset_seq #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_seq (
		.clk       (CLK),
		.rst_n     (RESET_N),
		.osc_ready (OSC_READY),
		.pin_hold  (~RST_PIN_N),
		.src_req   (src_req),
		.cpu_reset (seq_reset),
		.por_done  (por_done)
	);

	// bus decode
	assign access    = (READ | WRITE) & ~wait_reg;
	assign wr_lo     = access & WRITE & BYTEENABLE[0];
	assign hit_pc    = ADDRESS == {rbc_pkg::IDX_POWER_CONTROL, 2'h0};
	assign hit_sm    = ADDRESS == {rbc_pkg::IDX_SUPPLY_MONITOR, 2'h0};
	assign hit_ist   = ADDRESS == {rbc_pkg::IDX_IRQ_STATUS, 2'h0};
	assign hit_imk   = ADDRESS == {rbc_pkg::IDX_IRQ_MASK, 2'h0};
	assign hit_cause = ADDRESS == {rbc_pkg::IDX_RESET_CAUSE, 2'h0};
	assign hit_cmd   = ADDRESS == {rbc_pkg::IDX_RESET_COMMAND, 2'h0};

	always_comb begin
		sm_view = '0;
		sm_view[rbc_pkg::SM_DETECT_EN_BIT] = detect_en_reg;
		sm_view[rbc_pkg::SM_LEVEL_BIT]     = level_sel_reg;
		sm_view[rbc_pkg::SM_RESET_EN_BIT]  = reset_en_reg;
		sm_view[rbc_pkg::SM_EVENT_BIT]     = event_flag_reg;
	end

	// one wait cycle per access: low for exactly one edge
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= ~((READ | WRITE) & wait_reg);
		end
	end

	// read data captured while waitrequest is still high; unmapped reads zero
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_reg <= '0;
		end else if (READ && wait_reg) begin
			rdata_reg <= '0;
			if (hit_pc) begin
				rdata_reg[rbc_pkg::REG_W-1:0] <= power_control_reg;
			end else if (hit_sm) begin
				rdata_reg[rbc_pkg::REG_W-1:0] <= sm_view;
			end else if (hit_ist) begin
				rdata_reg[rbc_pkg::IRQ_W-1:0] <= irq_status_reg;
			end else if (hit_imk) begin
				rdata_reg[rbc_pkg::IRQ_W-1:0] <= irq_mask_reg;
			end else if (hit_cause) begin
				rdata_reg[rbc_pkg::CAUSE_W-1:0] <= cause_reg;
			end
		end
	end

	// power_control: cold-start flag survives every non power-on reset
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			power_control_reg <= rbc_pkg::PC_RESET_VALUE;
		end else if (por_done) begin
			power_control_reg <= rbc_pkg::PC_RESET_VALUE;
			power_control_reg[rbc_pkg::PC_COLD_START_BIT] <= 1'b1;
		end else if (seq_reset) begin
			// other bits back to reset value, flag kept
			power_control_reg <= (rbc_pkg::PC_RESET_VALUE & ~(8'h01 << rbc_pkg::PC_COLD_START_BIT)) |
			                     (power_control_reg & (8'h01 << rbc_pkg::PC_COLD_START_BIT));
		end else if (wr_lo && hit_pc) begin
			// software may clear the flag after startup
			power_control_reg <= WRITEDATA[rbc_pkg::REG_W-1:0] & rbc_pkg::PC_WRITE_MASK;
		end
	end

	// supply_monitor_control: detect enable and level reloaded from config, reset enable cleared, at every reset
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			detect_en_reg <= 1'b0;
		end else if (seq_reset) begin
			detect_en_reg <= ~CFG_BROWNOUT_DISABLE;
		end else if (wr_lo && hit_sm) begin
			detect_en_reg <= WRITEDATA[rbc_pkg::SM_DETECT_EN_BIT];
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			level_sel_reg <= rbc_pkg::LEVEL_SEL_2V7;
		end else if (seq_reset) begin
			// config one picks the low threshold
			level_sel_reg <= CFG_BROWNOUT_LEVEL ? rbc_pkg::LEVEL_SEL_2V7
			                                    : rbc_pkg::LEVEL_SEL_3V8;
		end else if (wr_lo && hit_sm) begin
			level_sel_reg <= WRITEDATA[rbc_pkg::SM_LEVEL_BIT];
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			reset_en_reg <= rbc_pkg::SM_RESET_EN_RESET;
		end else if (seq_reset) begin
			reset_en_reg <= rbc_pkg::SM_RESET_EN_RESET;
		end else if (wr_lo && hit_sm) begin
			reset_en_reg <= WRITEDATA[rbc_pkg::SM_RESET_EN_BIT];
		end
	end

	// event flag survives source resets so software can see it at startup
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			event_flag_reg <= 1'b0;
		end else if (flag_set) begin
			event_flag_reg <= 1'b1;
		end else if (wr_lo && hit_sm) begin
			event_flag_reg <= WRITEDATA[rbc_pkg::SM_EVENT_BIT];
		end
	end

	// reset cause flags: set by their source, kept until power-on or a bus write
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cause_reg <= '0;
		end else begin
			for (int i = 0; i < rbc_pkg::CAUSE_W; i++) begin
				if (wr_lo && hit_cause) begin
					cause_reg[i] <= WRITEDATA[i];
				end
			end
			if (sw_req_reg) begin
				cause_reg[rbc_pkg::CAUSE_SOFTWARE_BIT] <= 1'b1;
			end
			if (WATCHDOG_EXPIRE) begin
				cause_reg[rbc_pkg::CAUSE_WATCHDOG_BIT] <= 1'b1;
			end
			if (bod_reset_req) begin
				cause_reg[rbc_pkg::CAUSE_BROWNOUT_BIT] <= 1'b1;
			end
		end
	end

	// software reset command, one-cycle request
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sw_req_reg <= 1'b0;
		end else begin
			sw_req_reg <= wr_lo & hit_cmd & WRITEDATA[rbc_pkg::CMD_SW_RESET_BIT] & ~seq_reset;
		end
	end

	// interrupt status (read clears, set wins) and mask
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cpu_reset_prev_reg <= 1'b1;
		end else begin
			cpu_reset_prev_reg <= seq_reset;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_status_reg <= '0;
		end else begin
			if (access && READ && hit_ist) begin
				irq_status_reg <= '0;
			end
			if (flag_set) begin
				irq_status_reg[rbc_pkg::IRQ_BROWNOUT_BIT] <= 1'b1;
			end
			if (cpu_reset_prev_reg && !seq_reset) begin
				irq_status_reg[rbc_pkg::IRQ_SRC_RESET_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_mask_reg <= rbc_pkg::IRQ_MASK_RESET;
		end else if (wr_lo && hit_imk) begin
			irq_mask_reg <= WRITEDATA[rbc_pkg::IRQ_W-1:0];
		end
	end

	// registered outputs
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cpu_reset_out_reg <= 1'b1;
		end else begin
			cpu_reset_out_reg <= seq_reset;
		end
	end

	// pins P1.6, P1.7, P1.0, P1.1 in bits 3..0
	generate
		for (genvar p = 0; p < 4; p++) begin : g_p1_force
			always_ff @(posedge CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					p1_force_reg[p] <= 1'b1;
				end else begin
					p1_force_reg[p] <= seq_reset;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			det_en_out_reg <= 1'b0;
			level_out_reg  <= rbc_pkg::LEVEL_SEL_2V7;
		end else begin
			det_en_out_reg <= detect_en_reg;
			level_out_reg  <= level_sel_reg;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bod_irq_reg <= 1'b0;
		end else begin
			bod_irq_reg <= event_flag_reg & BROWNOUT_IRQ_ENABLE & GLOBAL_IRQ_ENABLE;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// no memory clearing: internal ram content is left to software
	assign READDATA               = rdata_reg;
	assign WAITREQUEST            = wait_reg;
	assign CPU_RESET              = cpu_reset_out_reg;
	assign CPU_START_ADDRESS      = rbc_pkg::RESET_VECTOR;
	assign P1_QUASI_FORCE         = p1_force_reg;
	assign BROWNOUT_DETECT_ENABLE = det_en_out_reg;
	assign BROWNOUT_LEVEL_SELECT  = level_out_reg;
	assign BROWNOUT_IRQ           = bod_irq_reg;
	assign IRQ                    = irq_reg;
endmodule // rbc_reset_brownout

//--- hdl/rbc_pkg.sv
// constants for the reset source and brown-out control block
package rbc_pkg;
	localparam int           ADDR_W             = 10;
	localparam int           DATA_W             = 32;
	localparam int           REG_W              = 8;
	// register indexes; the bus byte address is four times the index
	localparam logic [7:0]   IDX_POWER_CONTROL  = 8'h87;
	localparam logic [7:0]   IDX_SUPPLY_MONITOR = 8'hA3;
	localparam logic [7:0]   IDX_IRQ_STATUS     = 8'h00;
	localparam logic [7:0]   IDX_IRQ_MASK       = 8'h01;
	localparam logic [7:0]   IDX_RESET_CAUSE    = 8'h02;
	localparam logic [7:0]   IDX_RESET_COMMAND  = 8'h03;
	// power_control fields
	localparam int           PC_COLD_START_BIT  = 4;
	localparam logic [7:0]   PC_WRITE_MASK      = 8'hDF;
	localparam logic [7:0]   PC_RESET_VALUE     = 8'h00;
	// supply_monitor_control fields
	localparam int           SM_DETECT_EN_BIT   = 7;
	localparam int           SM_LEVEL_BIT       = 6;
	localparam int           SM_RESET_EN_BIT    = 4;
	localparam int           SM_EVENT_BIT       = 3;
	localparam logic         SM_RESET_EN_RESET  = 1'b0;
	// level select codes
	localparam logic         LEVEL_SEL_2V7      = 1'b0;
	localparam logic         LEVEL_SEL_3V8      = 1'b1;
	// interrupt status and mask fields
	localparam int           IRQ_W              = 2;
	localparam int           IRQ_BROWNOUT_BIT   = 0;
	localparam int           IRQ_SRC_RESET_BIT  = 1;
	localparam logic [1:0]   IRQ_MASK_RESET     = 2'h0;
	// reset cause flags
	localparam int           CAUSE_W            = 3;
	localparam int           CAUSE_SOFTWARE_BIT = 0;
	localparam int           CAUSE_WATCHDOG_BIT = 1;
	localparam int           CAUSE_BROWNOUT_BIT = 2;
	// reset command field
	localparam int           CMD_SW_RESET_BIT   = 0;
	// timing and vector
	localparam int           SRC_HOLD_CYCLES    = 24;
	localparam logic [15:0]  RESET_VECTOR       = 16'h0000;
	localparam logic [1:0]   P1_FORCE_PINS      = 2'h2;
endpackage : rbc_pkg

//--- hdl/rbc_sync_edge.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module rbc_sync_edge #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RESET_LEVEL;
			sync_reg <= RESET_LEVEL;
			last_reg <= RESET_LEVEL;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
	assign fall  = ~sync_reg & last_reg;
endmodule // rbc_sync_edge

//--- hdl/rbc_reset_seq.sv
// cpu reset sequencer: power-on wait for oscillator, then source holds
`timescale 1ns/100ps
module rbc_reset_seq #(
	parameter int HOLD_CYCLES = rbc_pkg::SRC_HOLD_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic osc_ready,
	input  wire logic pin_hold,
	input  wire logic src_req,
	output logic      cpu_reset,
	output logic      por_done
);
	typedef enum logic [2:0] {
		ST_POR  = 3'b001,
		ST_RUN  = 3'b010,
		ST_HOLD = 3'b100
	} rbc_seq_state_type;

	localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

	rbc_seq_state_type state_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic              cpu_reset_reg;
	logic              por_done_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= ST_POR;
			cnt_reg       <= '0;
			cpu_reset_reg <= 1'b1;
			por_done_reg  <= 1'b0;
		end else begin
			por_done_reg <= 1'b0;
			case (state_reg)
				ST_POR: begin
					if (osc_ready) begin
						state_reg     <= ST_RUN;
						cpu_reset_reg <= 1'b0;
						por_done_reg  <= 1'b1;
					end
				end
				ST_RUN: begin
					if (src_req || pin_hold) begin
						state_reg     <= ST_HOLD;
						cpu_reset_reg <= 1'b1;
						cnt_reg       <= CNT_W'(HOLD_CYCLES - 1);
					end
				end
				ST_HOLD: begin
					if (src_req || pin_hold) begin
						cnt_reg <= CNT_W'(HOLD_CYCLES - 1);
					end else if (cnt_reg == '0) begin
						state_reg     <= ST_RUN;
						cpu_reset_reg <= 1'b0;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					state_reg     <= ST_POR;
					cpu_reset_reg <= 1'b1;
				end
			endcase
		end
	end

	assign cpu_reset = cpu_reset_reg;
	assign por_done  = por_done_reg;
endmodule // rbc_reset_seq

//--- dv/rbc_supply_model.sv
// far-side model: oscillator start-up and supply comparator
`timescale 1ns/100ps
module rbc_supply_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic low_req,
	output logic      osc_ready,
	output logic      supply_above
);
	int osc_cnt;
	// oscillator runs only some cycles after power is good
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_cnt <= 0;
			osc_ready <= 1'b0;
		end else begin
			osc_cnt <= osc_cnt + 1;
			osc_ready <= (osc_cnt >= 9);
		end
	end
	// comparator moves off the clock edge
	assign #1.3 supply_above = !low_req;
endmodule // rbc_supply_model

//--- dv/rbc_reset_brownout_asserts.sv
// checker for bus handshake, reset hold and brown-out settings
`timescale 1ns/100ps
module rbc_reset_brownout_asserts #(
	parameter int HOLD_CYCLES = rbc_pkg::SRC_HOLD_CYCLES
) (
	input wire logic       CLK,
	input wire logic       RESET_N,
	input wire logic       RST_PIN_N,
	input wire logic       WATCHDOG_EXPIRE,
	input wire logic       CFG_BROWNOUT_DISABLE,
	input wire logic       CFG_BROWNOUT_LEVEL,
	input wire logic       BROWNOUT_IRQ_ENABLE,
	input wire logic       GLOBAL_IRQ_ENABLE,
	input wire logic       READ,
	input wire logic       WRITE,
	input wire logic       WAITREQUEST,
	input wire logic       CPU_RESET,
	input wire logic [3:0] P1_QUASI_FORCE,
	input wire logic       BROWNOUT_DETECT_ENABLE,
	input wire logic       BROWNOUT_LEVEL_SELECT,
	input wire logic       BROWNOUT_IRQ
);
	int run_cnt;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			run_cnt <= 0;
		else
			run_cnt <= CPU_RESET ? run_cnt + 1 : 0;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	sequence req_wait;
		(READ || WRITE) && WAITREQUEST;
	endsequence
	sequence held_rst;
		CPU_RESET [*4];
	endsequence
	AST_WAIT_ONE: assert property (req_wait |=> !WAITREQUEST ##1 WAITREQUEST)
		else $error("wait cycle count wrong");
	AST_P1_RUN: assert property (!CPU_RESET ##1 !CPU_RESET |-> P1_QUASI_FORCE == 4'h0)
		else $error("pins forced outside reset");
	AST_DET_LOAD: assert property (held_rst |-> BROWNOUT_DETECT_ENABLE == !CFG_BROWNOUT_DISABLE)
		else $error("detect enable not loaded");
	AST_LVL_LOAD: assert property (held_rst |-> BROWNOUT_LEVEL_SELECT == !CFG_BROWNOUT_LEVEL)
		else $error("level select not loaded");
	AST_PIN_RST: assert property (!RST_PIN_N [*6] |-> CPU_RESET)
		else $error("pin low without cpu reset");
	AST_WDOG_RST: assert property (WATCHDOG_EXPIRE && !CPU_RESET |-> ##[1:6] CPU_RESET)
		else $error("watchdog without cpu reset");
	AST_HOLD: assert property ($fell(CPU_RESET) |-> run_cnt >= HOLD_CYCLES - 1)
		else $error("cpu reset too short");
	AST_BIRQ_EN: assert property (BROWNOUT_IRQ |-> $past(BROWNOUT_IRQ_ENABLE && GLOBAL_IRQ_ENABLE))
		else $error("brown-out irq without enables");
endmodule // rbc_reset_brownout_asserts
bind rbc_reset_brownout rbc_reset_brownout_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) chk_inst (
	.CLK(CLK), .RESET_N(RESET_N), .RST_PIN_N(RST_PIN_N), .WATCHDOG_EXPIRE(WATCHDOG_EXPIRE),
	.CFG_BROWNOUT_DISABLE(CFG_BROWNOUT_DISABLE), .CFG_BROWNOUT_LEVEL(CFG_BROWNOUT_LEVEL),
	.BROWNOUT_IRQ_ENABLE(BROWNOUT_IRQ_ENABLE), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
	.READ(READ), .WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .CPU_RESET(CPU_RESET),
	.P1_QUASI_FORCE(P1_QUASI_FORCE), .BROWNOUT_DETECT_ENABLE(BROWNOUT_DETECT_ENABLE),
	.BROWNOUT_LEVEL_SELECT(BROWNOUT_LEVEL_SELECT), .BROWNOUT_IRQ(BROWNOUT_IRQ));

//--- dv/rbc_reset_brownout_tb.sv
// self-checking bench for the reset source and brown-out block
`timescale 1ns/100ps
module rbc_reset_brownout_tb;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        pin_n = 1'b1;
	logic        wdog = 1'b0;
	logic        low_req = 1'b0;
	logic        birq_en = 1'b0;
	logic        girq_en = 1'b0;
	logic        cfg_dis = 1'b0;
	logic        cfg_lvl = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [9:0]  addr = 10'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  be = 4'hF;
	logic        waitreq, cpu_rst, det_en, lvl_sel, birq, irq, osc, supply;
	logic [31:0] rdata, q;
	logic [15:0] start;
	logic [3:0]  p1;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          cold_m, cause_m, ev_m;
	always #2 clk = !clk;
	rbc_supply_model rbc_supply_model_inst (.clk(clk), .rst_n(reset_n), .low_req(low_req),
		.osc_ready(osc), .supply_above(supply));
	rbc_reset_brownout #(.HOLD_CYCLES(4)) rbc_reset_brownout_inst (.CLK(clk), .RESET_N(reset_n),
		.OSC_READY(osc), .RST_PIN_N(pin_n), .WATCHDOG_EXPIRE(wdog), .SUPPLY_ABOVE_LEVEL(supply),
		.CFG_BROWNOUT_DISABLE(cfg_dis), .CFG_BROWNOUT_LEVEL(cfg_lvl), .BROWNOUT_IRQ_ENABLE(birq_en),
		.GLOBAL_IRQ_ENABLE(girq_en), .ADDRESS(addr), .READ(rd), .WRITE(wr), .WRITEDATA(wdata),
		.BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(waitreq), .CPU_RESET(cpu_rst),
		.CPU_START_ADDRESS(start), .P1_QUASI_FORCE(p1), .BROWNOUT_DETECT_ENABLE(det_en),
		.BROWNOUT_LEVEL_SELECT(lvl_sel), .BROWNOUT_IRQ(birq), .IRQ(irq));
	task automatic results();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_pin(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= {i, 2'b00};
		wdata <= d;
		be <= b;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [7:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h0000_0000, 4'hF);
		chk_reg(n, e, q);
	endtask
	function automatic logic [31:0] sm_v(input logic det, input logic ev);
		return 32'({det, !cfg_lvl, 2'b00, ev, 3'b000});
	endfunction
	task automatic wait_rst(input logic v);
		repeat (300) if (cpu_rst !== v) @(posedge clk);
	endtask
	// checks common to every reset exit
	task automatic after_rst();
		wait_rst(1'b0);
		chk_pin("cpu_run", 1'b0, cpu_rst);
		chk_pin("detect_en", !cfg_dis, det_en);
		chk_pin("level_sel", !cfg_lvl, lvl_sel);
		rd_chk("power_control", rbc_pkg::IDX_POWER_CONTROL, 32'(cold_m << 4));
		rd_chk("reset_cause", rbc_pkg::IDX_RESET_CAUSE, 32'(cause_m));
		rd_chk("monitor", rbc_pkg::IDX_SUPPLY_MONITOR, sm_v(!cfg_dis, ev_m[0]));
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		void'($urandom(47));
		cfg_dis = 1'($urandom);
		cfg_lvl = 1'($urandom);
		cold_m = 1;
		cause_m = 0;
		ev_m = 0;
		repeat (6) @(posedge clk);
		chk_pin("cpu_reset", 1'b1, cpu_rst);
		chk_pin("p1_force", 1'b1, &p1);
		reset_n <= 1'b1;
		after_rst();
		chk_reg("start", 32'h0000_0000, 32'(start));
		for (int i = 0; i < 3; i++) begin
			if (i == 1) begin
				bus(1'b1, rbc_pkg::IDX_POWER_CONTROL, 32'h0000_00EF, 4'h0);
				rd_chk("pc_no_be", rbc_pkg::IDX_POWER_CONTROL, 32'h0000_0010);
				bus(1'b1, rbc_pkg::IDX_POWER_CONTROL, 32'h0000_00EF, 4'hF);
				rd_chk("pc_write", rbc_pkg::IDX_POWER_CONTROL, 32'h0000_00CF);
				rd_chk("unmapped", 8'h40, 32'h0000_0000);
				cold_m = 0;
			end
			cfg_dis <= 1'($urandom);
			cfg_lvl <= 1'($urandom);
			if (i == 0) begin
				wdog <= 1'b1;
				@(posedge clk);
				wdog <= 1'b0;
				cause_m |= 2;
			end else if (i == 1) begin
				bus(1'b1, rbc_pkg::IDX_RESET_COMMAND, 32'h0000_0001, 4'hF);
				cause_m |= 1;
			end else begin
				pin_n <= 1'b0;
				repeat (8) @(posedge clk);
				pin_n <= 1'b1;
			end
			wait_rst(1'b1);
			@(posedge clk);
			chk_pin("p1_force", 1'b1, &p1);
			after_rst();
		end
		// brown-out with reset enabled
		bus(1'b1, rbc_pkg::IDX_SUPPLY_MONITOR, 32'({1'b1, !cfg_lvl, 2'b01, 4'h0}), 4'hF);
		low_req <= 1'b1;
		cause_m |= 4;
		ev_m = 1;
		wait_rst(1'b1);
		after_rst();
		bus(1'b1, rbc_pkg::IDX_SUPPLY_MONITOR, 32'({1'b1, !cfg_lvl, 6'h00}), 4'hF);
		low_req <= 1'b0;
		repeat (10) @(posedge clk);
		rd_chk("monitor_rise", rbc_pkg::IDX_SUPPLY_MONITOR, sm_v(1'b1, 1'b0));
		bus(1'b1, rbc_pkg::IDX_IRQ_MASK, 32'h0000_0000, 4'hF);
		rd_chk("irq_pending", rbc_pkg::IDX_IRQ_STATUS, 32'h0000_0003);
		low_req <= 1'b1;
		repeat (10) @(posedge clk);
		chk_pin("cpu_reset", 1'b0, cpu_rst);
		chk_pin("irq_masked", 1'b0, irq);
		rd_chk("monitor_fall", rbc_pkg::IDX_SUPPLY_MONITOR, sm_v(1'b1, 1'b1));
		bus(1'b1, rbc_pkg::IDX_IRQ_MASK, 32'h0000_0001, 4'hF);
		repeat (2) @(posedge clk);
		chk_pin("irq", 1'b1, irq);
		rd_chk("irq_status", rbc_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk_pin("irq_clear", 1'b0, irq);
		birq_en <= 1'b1;
		repeat (3) @(posedge clk);
		chk_pin("bo_irq_off", 1'b0, birq);
		girq_en <= 1'b1;
		repeat (3) @(posedge clk);
		chk_pin("bo_irq_on", 1'b1, birq);
		// rising crossing with reset enabled, cause cleared first
		bus(1'b1, rbc_pkg::IDX_RESET_CAUSE, 32'h0000_0000, 4'hF);
		cause_m = 4;
		bus(1'b1, rbc_pkg::IDX_SUPPLY_MONITOR, 32'({1'b1, !cfg_lvl, 2'b01, 4'h0}), 4'hF);
		low_req <= 1'b0;
		wait_rst(1'b1);
		after_rst();
		// power-on in mid-run: cold flag set again, causes and event flag cleared
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		cold_m = 1;
		cause_m = 0;
		ev_m = 0;
		after_rst();
		results();
	end
endmodule // rbc_reset_brownout_tb
